// file: bench/see_master.sv
// Serial bus master model: select, serial clock and serial data
`timescale 1ns/1ps
`default_nettype none
module see_master (
  input wire logic clock,
  output logic chip_select,
  output logic serial_clock,
  output logic serial_in
);
  // Half of the 160 ns serial clock period, in system clocks
  localparam int HALF = 16;
  initial begin
    chip_select = 1'b0;
    serial_clock = 1'b0;
    serial_in = 1'b0;
  end
  // Select change, then a gap of half a serial period
  task automatic set_cs(input logic lvl);
    @(negedge clock);
    chip_select = lvl;
    if (!lvl) begin
      serial_in = ~serial_in; // Deselected data line never keeps its value
    end
    repeat (HALF) @(negedge clock);
  endtask
  // One bit: data set while the clock is low, taken on the rise
  task automatic clock_bit(input logic b);
    serial_in = b;
    repeat (HALF) @(negedge clock);
    serial_clock = 1'b1;
    repeat (HALF) @(negedge clock);
    serial_clock = 1'b0;
  endtask
  // Bits hi down to lo of a frame, most significant first
  task automatic bits(input logic [24:0] f, input int hi, input int lo);
    for (int i = hi; i >= lo; i--) begin
      clock_bit(f[i]);
    end
  endtask
  // Whole frame; select drops before any further clock rise
  task automatic send(input logic [24:0] f, input logic long);
    set_cs(1'b1);
    bits(f, 24, long ? 0 : 16);
    set_cs(1'b0);
  endtask
endmodule
`default_nettype wire

// file: bench/serial_eeprom_program_control_tb_top.sv
// Testbench for the serial EEPROM programming logic
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_program_control_tb_top;
  localparam int PROG = 200;
  localparam logic [24:0] F_WEN = {1'b1, see_pkg::OP_EXT, see_pkg::EXT_WEN, 4'h0, 16'h0000};
  localparam logic [24:0] F_WDS = {1'b1, see_pkg::OP_EXT, see_pkg::EXT_WDS, 4'h5, 16'h0000};
  localparam logic [24:0] F_WRITE = {1'b1, see_pkg::OP_WRITE, 6'h2a, 16'ha5c3};
  localparam logic [24:0] F_WALL = {1'b1, see_pkg::OP_EXT, see_pkg::EXT_WALL, 4'h9, 16'h3c0f};
  localparam logic [24:0] F_ERASE = {1'b1, see_pkg::OP_ERASE, 6'h13, 16'h0000};
  localparam logic [24:0] F_EALL = {1'b1, see_pkg::OP_EXT, see_pkg::EXT_EALL, 4'h6, 16'h0000};
  logic clock = 1'b0;
  logic rst_n;
  logic chip_select;
  logic serial_clock;
  logic serial_in;
  logic serial_out;
  logic serial_out_oe_n;
  logic busy;
  int mismatches = 0;
  int cmp_count = 0;
  int busy_run = 0;
  int last_run = 0;
  int busy_starts = 0;
  // Clock generation
  always #2.5 clock = ~clock;
  see_prog #(.PROG_CYCLES(PROG)) see_prog_i (
    .clock(clock), .rst_n(rst_n), .chip_select(chip_select),
    .serial_clock(serial_clock), .serial_in(serial_in), .serial_out(serial_out),
    .serial_out_oe_n(serial_out_oe_n), .busy(busy)
  );
  see_master see_master_i (
    .clock(clock), .chip_select(chip_select), .serial_clock(serial_clock),
    .serial_in(serial_in)
  );
  // Length of each busy period and count of finished periods
  always @(posedge clock) begin
    if (busy === 1'b1) begin
      busy_run <= busy_run + 1;
    end else if (busy_run != 0) begin
      last_run <= busy_run;
      busy_run <= 0;
      busy_starts <= busy_starts + 1;
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Bounded wait until no programming cycle runs
  task automatic wait_idle();
    int i;
    for (i = 0; i < PROG + 100; i++) begin
      @(negedge clock);
      if (busy === 1'b0) begin
        break;
      end
    end
    if (i == PROG + 100) begin
      mismatches++;
      results();
    end else begin
      repeat (3) @(negedge clock);
    end
  endtask
  // Send a frame and judge whether one full programming cycle ran
  task automatic frame(input logic [24:0] f, input logic long, input logic prog);
    int s;
    s = busy_starts;
    see_master_i.send(f, long);
    wait_idle();
    check(16'(busy_starts - s), {15'h0000, prog});
    if (prog) begin
      check(16'(last_run), 16'(PROG));
    end
  endtask
  task automatic t_locked();
    frame(F_WRITE, 1'b1, 1'b0);
    frame(F_WALL, 1'b1, 1'b0);
    frame(F_EALL, 1'b0, 1'b0);
    check(see_prog_i.mem[6'h2a], 16'hffff);
    check(see_prog_i.mem[6'h00], 16'hffff);
    $display("test locked done");
  endtask
  // Poll status while busy, toggle select, clear ready by a new start bit
  task automatic t_poll();
    int s;
    frame(F_WEN, 1'b0, 1'b0);
    see_master_i.send(F_WRITE, 1'b1);
    see_master_i.set_cs(1'b1);
    check(16'({serial_out_oe_n, serial_out}), 16'h0000);
    see_master_i.set_cs(1'b0);
    check(16'(serial_out_oe_n), 16'h0001);
    see_master_i.set_cs(1'b1);
    wait_idle();
    check(16'({serial_out_oe_n, serial_out}), 16'h0001);
    check(16'(last_run), 16'(PROG));
    check(see_prog_i.mem[6'h2a], 16'ha5c3);
    s = busy_starts;
    see_master_i.clock_bit(1'b1);
    check(16'(serial_out_oe_n), 16'h0001);
    see_master_i.bits(F_EALL, 23, 16);
    see_master_i.set_cs(1'b0);
    wait_idle();
    check(16'(busy_starts - s), 16'h0001);
    check(see_prog_i.mem[6'h2a], 16'hffff);
    $display("test poll done");
  endtask
  task automatic t_ops();
    frame(F_WALL, 1'b1, 1'b1);
    check(see_prog_i.mem[6'h00], 16'h3c0f);
    check(see_prog_i.mem[6'h3f], 16'h3c0f);
    frame(F_ERASE, 1'b0, 1'b1);
    check(see_prog_i.mem[6'h13], 16'hffff);
    check(see_prog_i.mem[6'h14], 16'h3c0f);
    frame(F_EALL, 1'b0, 1'b1);
    check(see_prog_i.mem[6'h14], 16'hffff);
    frame(F_WRITE, 1'b1, 1'b1);
    check(see_prog_i.mem[6'h2a], 16'ha5c3);
    frame(F_WDS, 1'b0, 1'b0);
    frame(F_ERASE, 1'b0, 1'b0);
    frame(F_WALL, 1'b1, 1'b0);
    check(see_prog_i.mem[6'h2a], 16'ha5c3);
    check(see_prog_i.mem[6'h00], 16'hffff);
    $display("test ops done");
  endtask
  // Main sequence
  initial begin
    rst_n = 1'b0;
    repeat (6) @(negedge clock);
    rst_n = 1'b1;
    repeat (4) @(negedge clock);
    t_locked();
    t_poll();
    t_ops();
    results();
  end
endmodule
`default_nettype wire

// file: hw/see_prog.sv
// Serial EEPROM instruction decode, programming cycle and status output
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Frame is start one, two opcode bits, six address bits, sixteen data MSB first.
// - Input bits are taken on serial clock rising edges only while selected.
// - Write-disabled after reset; enable instruction permits programming until disable.
// - Word write and write-all are accepted only when write-enabled.
// - Select falling after programming frame starts timed cycle; busy meanwhile.
// - While selected after programming, output low when busy, high when ready.
// - Status shows on output without any serial clock pulses.
// - Write-all programs every location with the one frame data word.
// - Write disable blocks programming, effective when select falls.
// - Read frames are accepted whether write-enabled or not; they program nothing and no read data is output.
// - Erase sets all bits of addressed word to one by timed cycle.
// - Erase-all sets whole array to one by timed cycle.
// - Opcode zero decodes high address bits: 01 write-all, 00 disable, 10 erase-all.
// - Output is released whenever select is low.
// - Toggling select during programming leaves the cycle unaffected.
// - Once ready, a clocked start bit releases the output.
// - That start bit begins a new instruction; dropping select also resets.
module see_prog #(
  parameter int PROG_CYCLES = see_pkg::PROG_CYCLES
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic chip_select,
  input wire logic serial_clock,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_oe_n,
  output logic busy
);
  // ----------------------------------------
  // Input synchronisation
  // ----------------------------------------
  logic [2:0] pins_s;
  see_sync #(.WIDTH(3)) u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .async_in({chip_select, serial_clock, serial_in}),
    .sync_out(pins_s)
  );
  logic cs_s, sk_s, di_s, cs_d, sk_d;
  assign cs_s = pins_s[2];
  assign sk_s = pins_s[1];
  assign di_s = pins_s[0];
  // Edge history
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cs_d <= 1'b0;
      sk_d <= 1'b0;
    end else begin
      cs_d <= cs_s;
      sk_d <= sk_s;
    end
  end
  logic sk_rise, cs_fall;
  assign sk_rise = cs_s && sk_s && !sk_d;
  assign cs_fall = cs_d && !cs_s;

  // ----------------------------------------
  // Frame shifter
  // ----------------------------------------
  logic started;
  logic [4:0] bit_cnt;
  logic [23:0] shreg;
  logic prog_active;
  logic [31:0] prog_cnt;
  logic ready_shown;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      started <= 1'b0;
      bit_cnt <= '0;
      shreg <= '0;
    end else if (!cs_s) begin
      started <= 1'b0;
      bit_cnt <= '0;
    end else if (sk_rise && !prog_active) begin
      if (!started) begin
        started <= di_s;
        bit_cnt <= '0;
      end else if (bit_cnt != see_pkg::FULL_CNT) begin
        shreg <= {shreg[22:0], di_s};
        bit_cnt <= bit_cnt + 5'h01;
      end
    end
  end

  // Decode fields of the header
  logic [1:0] opc;
  logic [5:0] adr;
  logic [15:0] wdata;
  logic hdr_done, full_done;
  assign full_done = (bit_cnt == see_pkg::FULL_CNT);
  assign hdr_done = (bit_cnt == see_pkg::HDR_CNT);
  assign opc = full_done ? shreg[23:22] : shreg[7:6];
  assign adr = full_done ? shreg[21:16] : shreg[5:0];
  assign wdata = shreg[15:0];

  // ----------------------------------------
  // Action selection at select fall
  // ----------------------------------------
  logic wr_en;
  see_pkg::see_act_t next_act;
  logic next_fill_ones;
  always_comb begin
    next_act = see_pkg::SEE_ACT_NONE;
    next_fill_ones = 1'b0;
    if (started && full_done && wr_en) begin
      if (opc == see_pkg::OP_WRITE) begin
        next_act = see_pkg::SEE_ACT_WORD;
      end else if (opc == see_pkg::OP_EXT && adr[5:4] == see_pkg::EXT_WALL) begin
        next_act = see_pkg::SEE_ACT_ALL;
      end
    end else if (started && hdr_done) begin
      if (opc == see_pkg::OP_ERASE && wr_en) begin
        next_act = see_pkg::SEE_ACT_WORD;
        next_fill_ones = 1'b1;
      end else if (opc == see_pkg::OP_EXT && adr[5:4] == see_pkg::EXT_EALL && wr_en) begin
        next_act = see_pkg::SEE_ACT_ALL;
        next_fill_ones = 1'b1;
      end else if (opc == see_pkg::OP_EXT && adr[5:4] == see_pkg::EXT_WDS) begin
        next_act = see_pkg::SEE_ACT_WDS;
      end
    end
  end
  logic wen_hit;
  assign wen_hit = started && hdr_done && opc == see_pkg::OP_EXT &&
                   adr[5:4] == see_pkg::EXT_WEN;
  // Read frames are taken whatever the enable state and never program
  logic read_hit;
  assign read_hit = started && hdr_done && opc == see_pkg::OP_READ;

  // Write-enable latch, updated only as select falls
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_en <= 1'b0;
    end else if (cs_fall && !prog_active) begin
      if (wen_hit) begin
        wr_en <= 1'b1;
      end else if (next_act == see_pkg::SEE_ACT_WDS) begin
        wr_en <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Memory array and programming cycle
  // ----------------------------------------
  logic [15:0] mem [0:see_pkg::WORDS-1];
  logic [5:0] pend_adr;
  logic [15:0] pend_data;
  logic pend_all;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prog_active <= 1'b0;
      prog_cnt <= '0;
      pend_adr <= '0;
      pend_data <= '0;
      pend_all <= 1'b0;
    end else if (prog_active) begin
      if (prog_cnt == 32'(PROG_CYCLES - 1)) begin
        prog_active <= 1'b0;
      end
      prog_cnt <= prog_cnt + 32'h0000_0001;
    end else if (cs_fall && (next_act == see_pkg::SEE_ACT_WORD ||
                             next_act == see_pkg::SEE_ACT_ALL)) begin
      prog_active <= 1'b1;
      prog_cnt <= '0;
      pend_adr <= adr;
      pend_data <= next_fill_ones ? see_pkg::ERASED : wdata;
      pend_all <= (next_act == see_pkg::SEE_ACT_ALL);
    end
  end

  // Array update at end of the timed cycle
  genvar gi;
  generate
    for (gi = 0; gi < see_pkg::WORDS; gi++) begin : g_word
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          mem[gi] <= see_pkg::MEM_RST;
        end else if (prog_active && prog_cnt == 32'(PROG_CYCLES - 1) &&
                     (pend_all || pend_adr == 6'(gi))) begin
          mem[gi] <= pend_data;
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Status output
  // ----------------------------------------
  // Ready indication held after a cycle until a clocked start bit; deselect does not clear it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ready_shown <= 1'b0;
    end else if (prog_active) begin
      ready_shown <= 1'b1;
    end else if (sk_rise && !started && di_s) begin
      ready_shown <= 1'b0;
    end
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      serial_out <= 1'b0;
      serial_out_oe_n <= 1'b1;
      busy <= 1'b0;
    end else begin
      busy <= prog_active;
      serial_out <= !prog_active;
      serial_out_oe_n <= !(cs_s && (prog_active || ready_shown) &&
                           !(sk_rise && !started && di_s && !prog_active));
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_release_low;
    @(posedge clock) disable iff (!rst_n) !cs_s |=> serial_out_oe_n;
  endproperty
  a_release_low: assert property (p_release_low) else $error("output driven while deselected");
  property p_busy_low;
    @(posedge clock) disable iff (!rst_n) (prog_active && cs_s) |=> (!serial_out && !serial_out_oe_n);
  endproperty
  a_busy_low: assert property (p_busy_low) else $error("busy not shown low");
  property p_start;
    @(posedge clock) disable iff (!rst_n)
      (cs_fall && !prog_active && next_act == see_pkg::SEE_ACT_WORD) |=> prog_active;
  endproperty
  a_start: assert property (p_start) else $error("programming did not start");
  property p_disabled;
    @(posedge clock) disable iff (!rst_n) (cs_fall && !prog_active && !wr_en) |=> !prog_active;
  endproperty
  a_disabled: assert property (p_disabled) else $error("programming while disabled");
  property p_wds;
    @(posedge clock) disable iff (!rst_n)
      (cs_fall && !prog_active && next_act == see_pkg::SEE_ACT_WDS) |=> !wr_en;
  endproperty
  a_wds: assert property (p_wds) else $error("disable not applied");
  property p_wen;
    @(posedge clock) disable iff (!rst_n) (cs_fall && !prog_active && wen_hit) |=> wr_en;
  endproperty
  a_wen: assert property (p_wen) else $error("enable not applied");
  property p_hold;
    @(posedge clock) disable iff (!rst_n)
      (prog_active && prog_cnt == 32'h0000_0000) |-> ##1 prog_active[*8];
  endproperty
  a_hold: assert property (p_hold) else $error("cycle ended early");
  property p_ready;
    @(posedge clock) disable iff (!rst_n) $fell(prog_active) && cs_s |=> serial_out;
  endproperty
  a_ready: assert property (p_ready) else $error("ready not shown");
  property p_read;
    @(posedge clock) disable iff (!rst_n)
      (cs_fall && !prog_active && read_hit) |=> (wr_en == $past(wr_en)) && !prog_active;
  endproperty
  a_read: assert property (p_read) else $error("read frame changed state");
  property p_write_word;
    @(posedge clock) disable iff (!rst_n)
      (cs_fall && !prog_active && next_act == see_pkg::SEE_ACT_WORD && !next_fill_ones) |=> pend_data == $past(wdata);
  endproperty
  a_write_word: assert property (p_write_word) else $error("write data not latched");
  property p_wall_all;
    @(posedge clock) disable iff (!rst_n)
      (prog_active && prog_cnt == 32'(PROG_CYCLES - 1) && pend_all) |=> (mem[0] == $past(pend_data)) && (mem[see_pkg::WORDS-1] == $past(pend_data));
  endproperty
  a_wall_all: assert property (p_wall_all) else $error("array not filled");
  property p_erase;
    @(posedge clock) disable iff (!rst_n)
      (cs_fall && !prog_active && next_fill_ones) |=> prog_active && pend_data == see_pkg::ERASED;
  endproperty
  a_erase: assert property (p_erase) else $error("erase data not ones");
  property p_eall;
    @(posedge clock) disable iff (!rst_n)
      (cs_fall && !prog_active && started && hdr_done && opc == see_pkg::OP_EXT && adr[5:4] == see_pkg::EXT_EALL && wr_en) |=> prog_active && pend_all;
  endproperty
  a_eall: assert property (p_eall) else $error("erase-all not decoded");
  property p_busy_cnt;
    @(posedge clock) disable iff (!rst_n)
      prog_active |-> prog_cnt < 32'(PROG_CYCLES);
  endproperty
  a_busy_cnt: assert property (p_busy_cnt) else $error("cycle overran");
  property p_busy_mirror;
    @(posedge clock) disable iff (!rst_n) 1'b1 |=> busy == $past(prog_active);
  endproperty
  a_busy_mirror: assert property (p_busy_mirror) else $error("busy out of step");
  property p_deselect_clear;
    @(posedge clock) disable iff (!rst_n) !cs_s |=> !started && bit_cnt == 5'h00;
  endproperty
  a_deselect_clear: assert property (p_deselect_clear) else $error("deselect kept frame");
  property p_ignore;
    @(posedge clock) disable iff (!rst_n) (prog_active && cs_s) |=> $stable(bit_cnt);
  endproperty
  a_ignore: assert property (p_ignore) else $error("bit taken while busy");
  property p_release_start;
    @(posedge clock) disable iff (!rst_n)
      (sk_rise && !started && di_s && !prog_active) |=> serial_out_oe_n && started;
  endproperty
  a_release_start: assert property (p_release_start) else $error("start bit kept output");
  property p_ready_hold;
    @(posedge clock) disable iff (!rst_n)
      (ready_shown && !prog_active && cs_s && !sk_rise) |=> !serial_out_oe_n && serial_out;
  endproperty
  a_ready_hold: assert property (p_ready_hold) else $error("ready not held");
endmodule
`default_nettype wire

// file: hw/see_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module see_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;
  // First stage feeds only the second
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule
`default_nettype wire

// file: pkg/see_pkg.sv
// Constants and types shared by the serial EEPROM programming logic
package see_pkg;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 16;
  localparam int WORDS = 64;
  localparam int OP_W = 2;
  // Frame bit counts after the start bit
  localparam int HDR_BITS = 8;
  localparam int FRAME_BITS = 24;
  localparam logic [4:0] HDR_CNT = 5'h08;
  localparam logic [4:0] FULL_CNT = 5'h18;
  // Opcodes
  localparam logic [1:0] OP_EXT = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_ERASE = 2'h3;
  // Extended decode on two high address bits
  localparam logic [1:0] EXT_WDS = 2'h0;
  localparam logic [1:0] EXT_WALL = 2'h1;
  localparam logic [1:0] EXT_EALL = 2'h2;
  localparam logic [1:0] EXT_WEN = 2'h3;
  localparam logic [DATA_W-1:0] ERASED = 16'hFFFF;
  localparam logic [DATA_W-1:0] MEM_RST = 16'hFFFF;
  // Programming time
  localparam int PROG_TIME_NS = 10000;
  localparam int CLK_PERIOD_NS = 5;
  localparam int PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Pending programming action
  typedef enum logic [3:0] {
    SEE_ACT_NONE = 4'b0001,
    SEE_ACT_WORD = 4'b0010,
    SEE_ACT_ALL = 4'b0100,
    SEE_ACT_WDS = 4'b1000
  } see_act_t;
endpackage
